// File: logic/mfid_top.sv
// Multi-function contact input decoder: faults, braking, search, mode switches
`timescale 1ns/100ps
`default_nettype none
// Notes on behaviour
// - Sixteen external fault codes, all combinations
// - Even code normally open, odd normally closed
// - First two per group always, last two running
// - Groups: decelerate, coast, emergency, continue
// - Open faults when on, closed when off
// - Running-only variants checked only while operating
// - Decelerate: fault plus normal deceleration ramp
// - Coast: fault plus immediate output cutoff
// - Emergency: fault plus fast-stop time ramp
// - Continue: alarm only, keep running
// - Refuse duplicate external fault code assignment
// - DC injection brakes when stopped; excites under vector
// - Run or jog ends braking, starts motor
// - Search from maximum or present reference
// - Search done when current drops during sweep
// - After search accelerate with acceleration time
// - Wait minimum output-off interval before searching
// - Only one external search function assigned
// - Mode input off speed, on torque
// - Position lock below zero-speed level
// - Gain switch forces gain two, integral unchanged
module mfid_top
  import mfid_pkg::*;
#(
  parameter int unsigned NUM_IN      = 8,                // Number of contacts
  parameter int unsigned MIN_OFF_CYC =
    (MIN_OFF_TIME_US * NS_PER_US) / CLK_PERIOD_NS,       // Output-off wait
  parameter int unsigned SWEEP_DIV   = 16                // Cycles per sweep step
) (
  input  wire logic                        CLOCK_I,          // System clock
  input  wire logic                        RESETN_I,         // Sync reset, low
  input  wire logic                        CE_I,             // Clock enable
  input  wire logic [NUM_IN-1:0]           CONTACT_I,        // Contact pins
  input  wire logic [NUM_IN*mfid_pkg::CODE_W-1:0] FUNC_SEL_I, // Codes per input
  input  wire logic                        RUNNING_I,        // Drive operating
  input  wire logic                        RUN_CMD_I,        // Run command
  input  wire logic                        JOG_CMD_I,        // Any jog command
  input  wire logic                        FLUX_VECTOR_I,    // Flux vector mode
  input  wire logic                        FAULT_RESET_I,    // Clear held fault
  input  wire logic [mfid_pkg::FREQ_W-1:0] MAX_FREQ_I,       // Maximum frequency
  input  wire logic [mfid_pkg::FREQ_W-1:0] REF_FREQ_I,       // Present reference
  input  wire logic [mfid_pkg::FREQ_W-1:0] SWEEP_STEP_I,     // Sweep decrement
  input  wire logic [mfid_pkg::CUR_W-1:0]  OUT_CURRENT_I,    // Output current
  input  wire logic [mfid_pkg::CUR_W-1:0]  SEARCH_CUR_LVL_I, // Done threshold
  input  wire logic [mfid_pkg::FREQ_W-1:0] SPEED_REF_I,      // Speed reference
  input  wire logic [mfid_pkg::FREQ_W-1:0] ZERO_SPEED_LEVEL_I, // Lock level
  input  wire logic                        NORMAL_GAIN_TWO_I, // Normal gain pick
  output mfid_pkg::mfid_stop_t             STOP_REQ_O,       // Stop request
  output logic                             CONFIG_ERR_O,     // Setting refused
  output logic                             DC_BRAKE_O,       // DC braking
  output logic                             INIT_EXCITE_O,    // Initial excitation
  output logic                             BASEBLOCK_O,      // Output held off
  output logic                             SEARCH_ACTIVE_O,  // Sweep running
  output logic [mfid_pkg::FREQ_W-1:0]      SEARCH_FREQ_O,    // Sweep frequency
  output logic                             SEARCH_DONE_O,    // One-cycle pulse
  output logic                             ACCEL_TO_REF_O,   // Accelerate to ref
  output logic                             TORQUE_MODE_O,    // Torque control
  output logic                             POS_LOCK_O,       // Position loop on
  output logic                             GAIN_TWO_O,       // Use gain two
  output logic                             GAIN_TWO_FORCED_O // Gain forced
);

  import mfid_pkg::*;

  localparam int unsigned OFF_W = $clog2(MIN_OFF_CYC + 1);  // Wait counter width
  localparam int unsigned DIV_W = $clog2(SWEEP_DIV + 1);    // Divider width
  localparam logic [OFF_W-1:0] OFF_LAST = OFF_W'(MIN_OFF_CYC - 1);
  localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(SWEEP_DIV - 1);

  // ----------------------------------------------------------------------
  // Contact synchronisation
  // ----------------------------------------------------------------------
  logic [NUM_IN-1:0] contact_s;  // Sampled contact levels

  mfid_sync #(
    .WIDTH (NUM_IN)
  ) u_sync (
    .clk_i   (CLOCK_I),
    .rst_n_i (RESETN_I),
    .ce_i    (CE_I),
    .async_i (CONTACT_I),
    .sync_o  (contact_s)
  );

  // ----------------------------------------------------------------------
  // Per-input decode
  // ----------------------------------------------------------------------
  logic [NUM_IN-1:0] is_ext;     // Input holds an external fault code
  logic [NUM_IN-1:0] ext_hit;    // That input sees a fault right now
  logic [1:0]        ext_act [NUM_IN];  // Its stop action
  logic [NUM_IN-1:0] sel_dc;     // DC injection assigned and on
  logic [NUM_IN-1:0] sel_smx;    // Search from max assigned and on
  logic [NUM_IN-1:0] sel_srf;    // Search from reference assigned and on
  logic [NUM_IN-1:0] sel_trq;    // Mode switch on
  logic [NUM_IN-1:0] sel_lck;    // Position lock on
  logic [NUM_IN-1:0] sel_gsw;    // Gain switch on
  logic [NUM_IN-1:0] has_smx;    // Search from max assigned
  logic [NUM_IN-1:0] has_srf;    // Search from reference assigned

  genvar g;
  generate
    for (g = 0; g < NUM_IN; g++) begin : g_in
      logic [CODE_W-1:0] code;   // This input's function code
      logic              lvl;    // Its sampled level
      logic              active; // Level after polarity
      assign code = FUNC_SEL_I[g*CODE_W +: CODE_W];
      assign lvl  = contact_s[g];
      // Any code 20..2F is an external fault, three fields in the low nibble
      assign is_ext[g]  = (code[EXT_HI_HI:EXT_HI_LO] == EXT_FAULT_HI);
      // Odd codes are normally closed and fault on an open contact
      assign active     = code[EXT_NC_BIT] ? ~lvl : lvl;
      // Running-only codes look at the contact only while operating
      assign ext_hit[g] = is_ext[g] & active
                          & (~code[EXT_RUN_BIT] | RUNNING_I);
      assign ext_act[g] = code[EXT_ACT_HI:EXT_ACT_LO];
      assign sel_dc[g]  = (code == CODE_DC_INJ)  & lvl;
      assign has_smx[g] = (code == CODE_SRCH_MX);
      assign has_srf[g] = (code == CODE_SRCH_RF);
      assign sel_smx[g] = has_smx[g] & lvl;
      assign sel_srf[g] = has_srf[g] & lvl;
      assign sel_trq[g] = (code == CODE_TRQ_SW)  & lvl;
      assign sel_lck[g] = (code == CODE_POS_LK)  & lvl;
      assign sel_gsw[g] = (code == CODE_GAIN_SW) & lvl;
    end
  endgenerate

  // ----------------------------------------------------------------------
  // Configuration check
  // ----------------------------------------------------------------------
  logic cfg_err;  // Combinational verdict on the settings

  // Duplicated external fault setting or both search codes is refused
  always_comb begin
    cfg_err = (|has_smx) & (|has_srf);
    for (int i = 0; i < NUM_IN; i++) begin
      for (int j = i + 1; j < NUM_IN; j++) begin
        if (is_ext[i] && is_ext[j]) begin
          cfg_err = 1'b1;
        end
      end
    end
  end

  logic cfg_err_ff;  // Registered verdict; all functions gated by it

  // Registered so the gating never glitches on a settings change
  always_ff @(posedge CLOCK_I) begin
    if (!RESETN_I) begin
      cfg_err_ff <= 1'b0;
    end else if (CE_I) begin
      cfg_err_ff <= cfg_err;
    end
  end

  assign CONFIG_ERR_O = cfg_err_ff;

  // ----------------------------------------------------------------------
  // External fault collection
  // ----------------------------------------------------------------------
  logic hit_decel;  // Decelerate fault seen
  logic hit_coast;  // Coast fault seen
  logic hit_estop;  // Emergency fault seen
  logic hit_cont;   // Continue-with-alarm seen

  // Only one input may hold an external code, so OR over inputs is exact
  always_comb begin
    hit_decel = 1'b0;
    hit_coast = 1'b0;
    hit_estop = 1'b0;
    hit_cont  = 1'b0;
    for (int i = 0; i < NUM_IN; i++) begin
      if (ext_hit[i] && !cfg_err_ff) begin
        case (mfid_action_t'(ext_act[i]))
          ACT_DECEL: hit_decel = 1'b1;
          ACT_COAST: hit_coast = 1'b1;
          ACT_ESTOP: hit_estop = 1'b1;
          default:   hit_cont  = 1'b1;
        endcase
      end
    end
  end

  logic fault_ff;      // Held fault
  logic fast_stop_ff;  // Held fault uses fast_stop_time
  logic cutoff_ff;     // Held fault cuts the output
  logic alarm_ff;      // Alarm follows the contact
  logic fault_set;     // A stopping fault this cycle

  assign fault_set = hit_decel | hit_coast | hit_estop;

  // Faults latch; a reset request while a new fault arrives loses
  always_ff @(posedge CLOCK_I) begin
    if (!RESETN_I) begin
      fault_ff     <= 1'b0;
      fast_stop_ff <= 1'b0;
      cutoff_ff    <= 1'b0;
    end else if (CE_I) begin
      if (fault_set) begin
        fault_ff     <= 1'b1;
        fast_stop_ff <= fast_stop_ff | hit_estop;
        cutoff_ff    <= cutoff_ff | hit_coast;
      end else if (FAULT_RESET_I && !RUN_CMD_I) begin
        // A fault cannot be cleared while a run command stands
        fault_ff     <= 1'b0;
        fast_stop_ff <= 1'b0;
        cutoff_ff    <= 1'b0;
      end
    end
  end

  // Alarm is a level only; the drive keeps running
  always_ff @(posedge CLOCK_I) begin
    if (!RESETN_I) begin
      alarm_ff <= 1'b0;
    end else if (CE_I) begin
      alarm_ff <= hit_cont;
    end
  end

  // A coast cutoff overrides any ramp; emergency picks the short ramp
  always_comb begin
    STOP_REQ_O.fault     = fault_ff;
    STOP_REQ_O.alarm     = alarm_ff;
    STOP_REQ_O.cutoff    = cutoff_ff;
    STOP_REQ_O.ramp_down = fault_ff & ~cutoff_ff;
    STOP_REQ_O.fast_stop = fast_stop_ff & ~cutoff_ff;
  end

  // ----------------------------------------------------------------------
  // DC injection
  // ----------------------------------------------------------------------
  logic dc_brake_ff;   // DC braking applied
  logic excite_ff;     // Initial excitation applied
  logic dc_req;        // Braking wanted this cycle

  // Run or jog wins over the brake input at once
  assign dc_req = (|sel_dc) & ~cfg_err_ff & ~RUNNING_I
                  & ~RUN_CMD_I & ~JOG_CMD_I;

  // Flux vector drives excite instead of braking
  always_ff @(posedge CLOCK_I) begin
    if (!RESETN_I) begin
      dc_brake_ff <= 1'b0;
      excite_ff   <= 1'b0;
    end else if (CE_I) begin
      dc_brake_ff <= dc_req & ~FLUX_VECTOR_I;
      excite_ff   <= dc_req &  FLUX_VECTOR_I;
    end
  end

  assign DC_BRAKE_O    = dc_brake_ff;
  assign INIT_EXCITE_O = excite_ff;

  // ----------------------------------------------------------------------
  // Speed search
  // ----------------------------------------------------------------------
  mfid_srch_state_t  srch_ff;       // Search state
  mfid_srch_state_t  nxt_srch;      // Next search state
  logic [OFF_W-1:0]  off_cnt_ff;    // Output-off wait counter
  logic [DIV_W-1:0]  div_cnt_ff;    // Sweep pacing counter
  logic [FREQ_W-1:0] freq_ff;       // Sweep frequency
  logic              from_ref_ff;   // Start point is the reference
  logic              run_d_ff;      // Run command last cycle
  logic              done_ff;       // Completion pulse
  logic              run_rise;      // Run command just arrived
  logic              srch_in;       // Either search input on
  logic              sweep_tick;    // Step the sweep this cycle
  logic              cur_low;       // Current below the threshold

  assign run_rise   = RUN_CMD_I & ~run_d_ff;
  assign srch_in    = (sel_smx | sel_srf) != '0 && !cfg_err_ff;
  assign sweep_tick = (div_cnt_ff == DIV_LAST);
  assign cur_low    = (OUT_CURRENT_I < SEARCH_CUR_LVL_I);

  // Search steps; dropping the run command aborts from any state
  always_comb begin
    nxt_srch = srch_ff;
    case (srch_ff)
      SRCH_IDLE: begin
        if (run_rise && srch_in) begin
          nxt_srch = SRCH_WAIT;
        end
      end
      SRCH_WAIT: begin
        if (!RUN_CMD_I) begin
          nxt_srch = SRCH_IDLE;
        end else if (off_cnt_ff == OFF_LAST) begin
          nxt_srch = SRCH_SWEEP;
        end
      end
      SRCH_SWEEP: begin
        if (!RUN_CMD_I) begin
          nxt_srch = SRCH_IDLE;
        end else if (cur_low) begin
          nxt_srch = SRCH_ACCEL;
        end
      end
      SRCH_ACCEL: begin
        if (!RUN_CMD_I) begin
          nxt_srch = SRCH_IDLE;
        end
      end
      default: nxt_srch = SRCH_IDLE;
    endcase
  end

  // State register
  always_ff @(posedge CLOCK_I) begin
    if (!RESETN_I) begin
      srch_ff  <= SRCH_IDLE;
      run_d_ff <= 1'b0;
    end else if (CE_I) begin
      srch_ff  <= nxt_srch;
      run_d_ff <= RUN_CMD_I;
    end
  end

  // Start point chosen at the run edge, held for the whole search
  always_ff @(posedge CLOCK_I) begin
    if (!RESETN_I) begin
      from_ref_ff <= 1'b0;
    end else if (CE_I && srch_ff == SRCH_IDLE && nxt_srch == SRCH_WAIT) begin
      from_ref_ff <= |sel_srf;
    end
  end

  // Output-off interval counter, cleared outside the wait
  always_ff @(posedge CLOCK_I) begin
    if (!RESETN_I) begin
      off_cnt_ff <= '0;
    end else if (CE_I) begin
      if (srch_ff == SRCH_WAIT) begin
        off_cnt_ff <= off_cnt_ff + 1'b1;
      end else begin
        off_cnt_ff <= '0;
      end
    end
  end

  // Sweep frequency: loaded on entry, stepped down, floored at zero
  always_ff @(posedge CLOCK_I) begin
    if (!RESETN_I) begin
      freq_ff    <= '0;
      div_cnt_ff <= '0;
    end else if (CE_I) begin
      if (srch_ff != SRCH_SWEEP) begin
        freq_ff    <= from_ref_ff ? REF_FREQ_I : MAX_FREQ_I;
        div_cnt_ff <= '0;
      end else begin
        div_cnt_ff <= sweep_tick ? '0 : div_cnt_ff + 1'b1;
        if (sweep_tick) begin
          // Sweeping downward keeps the current in check near sync
          freq_ff <= (freq_ff > SWEEP_STEP_I) ?
                     freq_ff - SWEEP_STEP_I : '0;
        end
      end
    end
  end

  // One-cycle completion pulse on the sweep-to-accelerate step
  always_ff @(posedge CLOCK_I) begin
    if (!RESETN_I) begin
      done_ff <= 1'b0;
    end else if (CE_I) begin
      done_ff <= (srch_ff == SRCH_SWEEP) && (nxt_srch == SRCH_ACCEL);
    end
  end

  assign BASEBLOCK_O     = (srch_ff == SRCH_WAIT);
  assign SEARCH_ACTIVE_O = (srch_ff == SRCH_SWEEP);
  assign SEARCH_FREQ_O   = freq_ff;
  assign SEARCH_DONE_O   = done_ff;
  assign ACCEL_TO_REF_O  = (srch_ff == SRCH_ACCEL);

  // ----------------------------------------------------------------------
  // Mode, position lock and gain switches
  // ----------------------------------------------------------------------
  logic torque_ff;  // Torque control selected
  logic lock_ff;    // Position loop closed
  logic gforce_ff;  // Gain two forced

  // Plain levels, registered so the control loops see clean edges
  always_ff @(posedge CLOCK_I) begin
    if (!RESETN_I) begin
      torque_ff <= 1'b0;
      lock_ff   <= 1'b0;
      gforce_ff <= 1'b0;
    end else if (CE_I) begin
      torque_ff <= (|sel_trq) & ~cfg_err_ff;
      lock_ff   <= (|sel_lck) & ~cfg_err_ff
                   & (SPEED_REF_I < ZERO_SPEED_LEVEL_I);
      gforce_ff <= (|sel_gsw) & ~cfg_err_ff;
    end
  end

  assign TORQUE_MODE_O     = torque_ff;
  assign POS_LOCK_O        = lock_ff;
  // Only proportional gain moves; integral time is not touched here
  assign GAIN_TWO_O        = gforce_ff | NORMAL_GAIN_TWO_I;
  assign GAIN_TWO_FORCED_O = gforce_ff;

endmodule : mfid_top
`default_nettype wire

// File: logic/mfid_pkg.sv
// Shared constants and types for the multi-function contact input decoder
package mfid_pkg;

  // ----------------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------------
  localparam int unsigned CLK_PERIOD_NS   = 20;   // 50 MHz system clock
  localparam int unsigned NS_PER_US       = 1000; // Unit conversion
  localparam int unsigned MIN_OFF_TIME_US = 500;  // Default output-off interval

  // ----------------------------------------------------------------------
  // Widths
  // ----------------------------------------------------------------------
  localparam int unsigned CODE_W = 8;   // Function code width
  localparam int unsigned FREQ_W = 16;  // Frequency word width
  localparam int unsigned CUR_W  = 12;  // Current word width

  // ----------------------------------------------------------------------
  // Function codes
  // ----------------------------------------------------------------------
  localparam logic [3:0]        EXT_FAULT_HI = 4'h2;  // Upper nibble of 20..2F
  localparam logic [CODE_W-1:0] CODE_DC_INJ  = 8'h60; // DC injection command
  localparam logic [CODE_W-1:0] CODE_SRCH_MX = 8'h61; // Search from max frequency
  localparam logic [CODE_W-1:0] CODE_SRCH_RF = 8'h62; // Search from reference
  localparam logic [CODE_W-1:0] CODE_TRQ_SW  = 8'h71; // Speed/torque mode switch
  localparam logic [CODE_W-1:0] CODE_POS_LK  = 8'h72; // Position-lock command
  localparam logic [CODE_W-1:0] CODE_GAIN_SW = 8'h77; // Speed-loop gain switch

  // ----------------------------------------------------------------------
  // External fault code field positions
  // ----------------------------------------------------------------------
  localparam int unsigned EXT_NC_BIT  = 0; // 1: normally closed
  localparam int unsigned EXT_RUN_BIT = 1; // 1: detect while running only
  localparam int unsigned EXT_ACT_LO  = 2; // Stop action field, low bit
  localparam int unsigned EXT_ACT_HI  = 3; // Stop action field, high bit
  localparam int unsigned EXT_HI_LO   = 4; // Group nibble, low bit
  localparam int unsigned EXT_HI_HI   = 7; // Group nibble, high bit

  // Stop action carried by the external fault codes
  typedef enum logic [1:0] {
    ACT_DECEL    = 2'b00,
    ACT_COAST    = 2'b01,
    ACT_ESTOP    = 2'b10,
    ACT_CONTINUE = 2'b11
  } mfid_action_t;

  // Stop request towards the motor sequencer
  typedef struct packed {
    logic fault;      // Fault output
    logic alarm;      // Alarm only, keep running
    logic ramp_down;  // Ramp output to zero
    logic fast_stop;  // Use fast_stop_time for the ramp
    logic cutoff;     // Cut power output at once
  } mfid_stop_t;

  // Speed search state
  typedef enum logic [1:0] {
    SRCH_IDLE  = 2'b00,
    SRCH_WAIT  = 2'b01,
    SRCH_SWEEP = 2'b10,
    SRCH_ACCEL = 2'b11
  } mfid_srch_state_t;

endpackage : mfid_pkg

// File: logic/mfid_sync.sv
// Two-stage synchroniser for a vector of contact inputs
`timescale 1ns/100ps
`default_nettype none
module mfid_sync #(
  parameter int unsigned WIDTH = 8  // Number of contacts
) (
  input  wire logic             clk_i,    // System clock
  input  wire logic             rst_n_i,  // Synchronous reset, active low
  input  wire logic             ce_i,     // Clock enable
  input  wire logic [WIDTH-1:0] async_i,  // Raw contact levels
  output logic      [WIDTH-1:0] sync_o    // Stable sampled levels
);

  // ----------------------------------------------------------------------
  // Per-bit double flop
  // ----------------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < WIDTH; g++) begin : g_bit
      logic meta_ff;  // First stage, read only by the second
      logic stab_ff;  // Second stage
      // Contacts bounce and are asynchronous, so never read meta_ff
      always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
          meta_ff <= 1'b0;
          stab_ff <= 1'b0;
        end else if (ce_i) begin
          meta_ff <= async_i[g];
          stab_ff <= meta_ff;
        end
      end
      assign sync_o[g] = stab_ff;
    end
  endgenerate

endmodule : mfid_sync
`default_nettype wire

// File: sim/mfid_chk.sv
// Concurrent checks on the decoder's outputs
`timescale 1ns/100ps
`default_nettype none
module mfid_chk (
  input wire logic                CLOCK_I,
  input wire logic                RESETN_I,
  input wire logic                RUN_CMD_I,
  input wire logic                JOG_CMD_I,
  input wire mfid_pkg::mfid_stop_t STOP_REQ_O,
  input wire logic                DC_BRAKE_O,
  input wire logic                INIT_EXCITE_O,
  input wire logic                BASEBLOCK_O,
  input wire logic                SEARCH_ACTIVE_O,
  input wire logic                SEARCH_DONE_O,
  input wire logic                ACCEL_TO_REF_O,
  input wire logic                GAIN_TWO_O,
  input wire logic                GAIN_TWO_FORCED_O
);
  import mfid_pkg::*;
  // One domain, so clock and reset are given once
  default clocking cb @(posedge CLOCK_I); endclocking
  default disable iff (!RESETN_I);
  AST_DECEL: assert property (STOP_REQ_O.ramp_down |-> STOP_REQ_O.fault)
    else $error("ramp without fault");
  AST_COAST: assert property (STOP_REQ_O.cutoff |-> STOP_REQ_O.fault)
    else $error("cutoff without fault");
  AST_ESTOP: assert property (STOP_REQ_O.fast_stop |-> STOP_REQ_O.fault)
    else $error("fast stop without fault");
  AST_ALARM: assert property (STOP_REQ_O.alarm |-> !STOP_REQ_O.fault)
    else $error("alarm came with fault");
  AST_DCX: assert property (!(DC_BRAKE_O && INIT_EXCITE_O))
    else $error("braking and excitation together");
  AST_RUNCLR: assert property ((DC_BRAKE_O || INIT_EXCITE_O) && (RUN_CMD_I || JOG_CMD_I)
    |=> !DC_BRAKE_O && !INIT_EXCITE_O)
    else $error("braking kept after run");
  AST_OFFWAIT: assert property ($rose(SEARCH_ACTIVE_O) |-> $past(BASEBLOCK_O))
    else $error("sweep began without output-off wait");
  AST_DONE: assert property (SEARCH_DONE_O |=> !SEARCH_DONE_O)
    else $error("done pulse too long");
  AST_ACC: assert property (SEARCH_DONE_O |-> ACCEL_TO_REF_O && !SEARCH_ACTIVE_O)
    else $error("no acceleration after search");
  AST_GAIN: assert property (GAIN_TWO_FORCED_O |-> GAIN_TWO_O)
    else $error("forced gain not applied");
endmodule : mfid_chk
bind mfid_top mfid_chk mfid_chk_i (.*);
`default_nettype wire

// File: sim/mfid_periph.sv
// Peripheral equipment model driving the contact pins
`timescale 1ns/100ps
`default_nettype none
module mfid_periph (
  input  wire logic       clk_i,     // System clock
  input  wire logic [7:0] want_i,    // Requested contact levels
  output logic      [7:0] contact_o  // Contact pins
);
  // Switches move off the clock edge, as real contacts are unrelated to it
  always @(posedge clk_i) contact_o <= #3 want_i;
endmodule : mfid_periph
`default_nettype wire

// File: sim/tb_mfid_top.sv
// Self-checking bench for the contact input decoder
`timescale 1ns/100ps
`default_nettype none
module tb_mfid_top;
  import mfid_pkg::*;
  logic CLOCK_I, RESETN_I, CE_I, RUNNING_I, RUN_CMD_I, JOG_CMD_I, FLUX_VECTOR_I, FAULT_RESET_I;
  logic NORMAL_GAIN_TWO_I, CONFIG_ERR_O, DC_BRAKE_O, INIT_EXCITE_O, BASEBLOCK_O;
  logic SEARCH_ACTIVE_O, SEARCH_DONE_O, ACCEL_TO_REF_O, TORQUE_MODE_O, POS_LOCK_O;
  logic GAIN_TWO_O, GAIN_TWO_FORCED_O;
  logic [7:0]  want, CONTACT_I;   // Requested and actual contact levels
  logic [63:0] FUNC_SEL_I;
  logic [15:0] MAX_FREQ_I, REF_FREQ_I, SWEEP_STEP_I, SPEED_REF_I, ZERO_SPEED_LEVEL_I;
  logic [15:0] SEARCH_FREQ_O;
  logic [11:0] OUT_CURRENT_I, SEARCH_CUR_LVL_I;
  mfid_stop_t  STOP_REQ_O;
  int          err_count, num_checks, cyc;
  // Short off-wait and sweep divider keep the run brief
  mfid_top #(.MIN_OFF_CYC(4), .SWEEP_DIV(2)) mfid_top_i (.*);
  mfid_periph mfid_periph_i (.clk_i(CLOCK_I), .want_i(want), .contact_o(CONTACT_I));
  initial begin
    CLOCK_I = 1'b0;
    forever #10 CLOCK_I = ~CLOCK_I;
  end
  // Watchdog: all tests need well under this many cycles
  always @(posedge CLOCK_I) begin
    cyc++;
    if (cyc == 20000) begin
      err_count++;
      end_of_test();
    end
  end
  task automatic tick(input int n); repeat (n) @(posedge CLOCK_I); endtask : tick
  task automatic settle; @(negedge CLOCK_I); endtask : settle
  task automatic chk_word(input logic [15:0] got, input logic [15:0] exp, input string m);
    num_checks++;
    if (got !== exp) begin
      err_count++;
      $display("CHECK FAILED t=%0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask : chk_word
  task automatic chk_stop(input mfid_stop_t got, input mfid_stop_t exp);
    chk_word({11'h0, got}, {11'h0, exp}, "stop request");
  endtask : chk_stop
  // Reset with all commands idle, contact 0 at a chosen level and the other contacts low
  task automatic rst(input int n, input logic w);
    @(posedge CLOCK_I);
    RESETN_I <= 1'b0; want <= {7'h0, w}; FUNC_SEL_I <= '0; RUNNING_I <= 1'b0;
    RUN_CMD_I <= 1'b0; JOG_CMD_I <= 1'b0; FLUX_VECTOR_I <= 1'b0; OUT_CURRENT_I <= 12'h800;
    FAULT_RESET_I <= 1'b0;
    tick(n);
    RESETN_I <= 1'b1;
  endtask : rst
  // One external fault code, drive stopped or running
  task automatic t_fault(input logic [3:0] lo, input logic run);
    mfid_stop_t e;
    logic det;
    det = run | ~lo[1];
    e = '0;
    e.fault = det & (lo[3:2] != 2'b11); e.alarm = det & (lo[3:2] == 2'b11);
    e.ramp_down = det & ~lo[2]; e.fast_stop = det & (lo[3:2] == 2'b10);
    e.cutoff = det & (lo[3:2] == 2'b01);
    rst(2, lo[0]);
    RUNNING_I <= run;
    tick(3);
    FUNC_SEL_I <= {56'h0, EXT_FAULT_HI, lo};
    tick(3); settle; chk_stop(STOP_REQ_O, '0);
    @(posedge CLOCK_I) want <= {7'h0, ~lo[0]};
    tick(4); settle; chk_stop(STOP_REQ_O, e);
    want <= {7'h0, lo[0]}; FAULT_RESET_I <= 1'b1;
    tick(4); settle; chk_stop(STOP_REQ_O, '0);
  endtask : t_fault
  task automatic t_cfg(input logic [15:0] pair, input logic exp);
    rst(2, 1'b0);
    tick(2); FUNC_SEL_I <= {48'h0, pair};
    tick(3); settle; chk_word(CONFIG_ERR_O, exp, "setting refusal");
  endtask : t_cfg
  task automatic t_dc(input logic fv, input logic jog);
    rst(2, 1'b1);
    FLUX_VECTOR_I <= fv; FUNC_SEL_I <= 64'h60;
    tick(4); settle; chk_word({DC_BRAKE_O, INIT_EXCITE_O}, {~fv, fv}, "braking");
    @(posedge CLOCK_I) if (jog) JOG_CMD_I <= 1'b1; else RUN_CMD_I <= 1'b1;
    tick(2); settle; chk_word({DC_BRAKE_O, INIT_EXCITE_O}, 16'h0, "run clears");
    $display("test braking done");
  endtask : t_dc
  task automatic t_srch(input logic [7:0] code, input logic [15:0] st);
    int n;
    rst(2, 1'b1);
    FUNC_SEL_I <= {56'h0, code}; SWEEP_STEP_I <= {11'h0, code[1:0], 3'h0};
    tick(4); RUN_CMD_I <= 1'b1;
    tick(2); settle; chk_word(BASEBLOCK_O, 16'h1, "output off");
    n = 0;
    while (SEARCH_ACTIVE_O !== 1'b1 && n < 20) begin settle; n++; end
    chk_word(16'(n), 16'h3, "off interval");
    chk_word(SEARCH_FREQ_O, st, "sweep start");
    tick(7); OUT_CURRENT_I <= 12'h010;
    n = 0;
    while (SEARCH_DONE_O !== 1'b1 && n < 40) begin settle; n++; end
    chk_word({SEARCH_FREQ_O < st, ACCEL_TO_REF_O}, 16'h3, "sweep end");
    @(posedge CLOCK_I) RUN_CMD_I <= 1'b0;
    $display("test search %h done", code);
  endtask : t_srch
  task automatic t_mode;
    rst(2, 1'b0);
    FUNC_SEL_I <= 64'h777271; SPEED_REF_I <= 16'h0005; want <= 8'h07;
    tick(4); settle; chk_word({TORQUE_MODE_O, POS_LOCK_O, GAIN_TWO_O, GAIN_TWO_FORCED_O},
      16'hf, "modes on");
    @(posedge CLOCK_I) want <= 8'h00;
    tick(4); settle; chk_word({TORQUE_MODE_O, POS_LOCK_O, GAIN_TWO_FORCED_O}, 16'h0,
      "modes off");
    $display("test modes done");
  endtask : t_mode
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : end_of_test
  initial begin
    RESETN_I = 1'b0; CE_I = 1'b1; want = 8'h00; FUNC_SEL_I = '0; RUNNING_I = 1'b0;
    RUN_CMD_I = 1'b0; JOG_CMD_I = 1'b0; FLUX_VECTOR_I = 1'b0; FAULT_RESET_I = 1'b0;
    MAX_FREQ_I = 16'h0400; REF_FREQ_I = 16'h0123; SWEEP_STEP_I = 16'h0010;
    OUT_CURRENT_I = 12'h800; SEARCH_CUR_LVL_I = 12'h100; SPEED_REF_I = 16'h0005;
    ZERO_SPEED_LEVEL_I = 16'h0010; NORMAL_GAIN_TWO_I = 1'b0;
    rst(16, 1'b0);
    for (int i = 0; i < 32; i++) t_fault(i[3:0], i[4]);
    $display("test faults done");
    t_cfg(16'h2d20, 1'b1);
    t_cfg(16'h6261, 1'b1);
    t_cfg(16'h6120, 1'b0);
    t_dc(1'b0, 1'b0);
    t_dc(1'b1, 1'b1);
    t_srch(8'h61, 16'h0400);
    t_srch(8'h62, 16'h0123);
    t_mode();
    end_of_test();
  end
endmodule : tb_mfid_top
`default_nettype wire
